// ==== scp_serial_port.sv ====
// serial control port slave: framing, shifting, config registers
`timescale 1ns/1ps
module scp_serial_port (
	input  wire logic ref_clk,         // 40 MHz system clock
	input  wire logic rst,             // async reset, active high
	input  wire logic sclk,            // serial shift clock pin
	input  wire logic csN,             // chip select pin, active low
	input  wire logic sdioIn,          // data line, input side
	output logic      sdioOut,         // data line, output side
	output logic      sdioOe,          // data line output enable
	input  wire logic ioUpdate,        // update strobe pin
	output logic      lsbFirst,        // active bit order setting
	output logic      updateStrobe,    // pulse on shadow transfer
	output logic      softResetStrobe  // pulse on soft reset
);
	import scp_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers and edge detection
	// ------------------------------------------------------------
	scp_pins_s pinsIn;
	scp_pins_s sync1_r;
	scp_pins_s sync2_r;
	scp_pins_s prev_r;
	logic      sclkRise;
	logic      sclkFall;
	logic      csLow;
	logic      csRise;
	logic      csFall;
	logic      updPinEdge;

	assign pinsIn = '{sclk: sclk, csN: csN, sdio: sdioIn, ioUpd: ioUpdate};

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync1_r <= PINS_RST;
			sync2_r <= PINS_RST;
			prev_r  <= PINS_RST;
		end else begin
			sync1_r <= pinsIn;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	assign sclkRise   = sync2_r.sclk & ~prev_r.sclk;
	assign sclkFall   = ~sync2_r.sclk & prev_r.sclk;
	assign csLow      = ~sync2_r.csN;
	assign csRise     = sync2_r.csN & ~prev_r.csN;
	assign csFall     = ~sync2_r.csN & prev_r.csN;
	assign updPinEdge = sync2_r.ioUpd & ~prev_r.ioUpd;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] shiftIn(input logic [15:0] sr,
		input logic d, input logic lsb, input logic wide);
		if (!lsb)
			shiftIn = {sr[14:0], d};
		else if (wide)
			shiftIn = {d, sr[15:1]};
		else
			shiftIn = {8'h00, d, sr[7:1]};
	endfunction

	function automatic logic [12:0] stepAddr(input logic [12:0] a,
		input logic lsb);
		stepAddr = lsb ? a + ADDR_STEP : a - ADDR_STEP;
	endfunction

	// soft reset reads back as zero, forced bits fixed, nibble mirrored
	function automatic logic [7:0] cfgWord(input logic lsb);
		cfgWord = {1'b0, lsb, 1'b0, 1'b1, 1'b1, 1'b0, lsb, 1'b0};
	endfunction

	// ------------------------------------------------------------
	// serial framing state
	// ------------------------------------------------------------
	scp_state_e  state_r, state_nxt;
	logic [3:0]  bitCnt_r, bitCnt_nxt;
	logic [15:0] shift_r, shift_nxt;
	scp_instr_s  instr_r, instr_nxt;
	logic [12:0] addr_r, addr_nxt;
	logic [1:0]  bytesDone_r, bytesDone_nxt;
	logic [7:0]  txByte_r, txByte_nxt;
	logic        sdioOut_r, sdioOut_nxt;
	logic        sdioOe_r, sdioOe_nxt;
	logic        onBoundary;
	logic        byteEnd;
	logic        wrEn;
	logic [12:0] wrAddr;
	logic [7:0]  wrData;
	logic [2:0]  rdBit;

	// config state, declared here because reads need it
	logic shadowLsb_r, shadowLsb_nxt;
	logic activeLsb_r, activeLsb_nxt;
	logic rdSel_r, rdSel_nxt;
	logic updStrobe_r, updStrobe_nxt;
	logic srstStrobe_r, srstStrobe_nxt;
	logic doUpd;
	logic srstHit;
	logic [7:0] cfgRead;

	assign cfgRead = cfgWord(rdSel_r ? shadowLsb_r : activeLsb_r);

	function automatic logic [7:0] readByte(input logic [12:0] a,
		input logic [7:0] cfg, input logic sel);
		if (a == CFG_ADDR)
			readByte = cfg;
		else if (a == RDSEL_ADDR)
			readByte = {7'h00, sel};
		else
			readByte = 8'h00;
	endfunction

	assign onBoundary = bitCnt_r[2:0] == 3'h0;
	assign byteEnd    = csLow && sclkRise && state_r == SCP_DATA
		&& bitCnt_r == BYTE_LAST;
	// bit index follows the count, so driving a bit twice is harmless
	assign rdBit      = activeLsb_r ? bitCnt_r[2:0] : ~bitCnt_r[2:0];

	always_comb begin
		logic [15:0] sh;
		sh            = shiftIn(shift_r, sync2_r.sdio, activeLsb_r,
			state_r == SCP_INSTR);
		state_nxt     = state_r;
		bitCnt_nxt    = bitCnt_r;
		shift_nxt     = shift_r;
		instr_nxt     = instr_r;
		addr_nxt      = addr_r;
		bytesDone_nxt = bytesDone_r;
		txByte_nxt    = txByte_r;
		sdioOut_nxt   = sdioOut_r;
		sdioOe_nxt    = sdioOe_r;
		wrEn          = 1'b0;
		wrAddr        = addr_r;
		wrData        = sh[7:0];
		if (!csLow) begin
			// pins ignored while deselected; line released
			sdioOe_nxt = 1'b0;
			// mid-byte rise flushes; this also ends a stalled
			// transfer after a short partial byte
			if (csRise && (!onBoundary || state_r == SCP_DONE
				|| (state_r == SCP_DATA
				&& instr_r.len == LEN_STREAM))) begin
				state_nxt     = SCP_INSTR;
				bitCnt_nxt    = 4'h0;
				bytesDone_nxt = 2'h0;
				shift_nxt     = 16'h0000;
			end
			// otherwise a boundary stall: everything is kept
		end else if (sclkRise) begin
			unique case (state_r)
				SCP_INSTR: begin
					shift_nxt  = sh;
					bitCnt_nxt = bitCnt_r + 4'h1;
					// only the sixteen-bit format is decoded
					if (bitCnt_r == INSTR_LAST) begin
						instr_nxt     = scp_instr_s'(sh);
						addr_nxt      = instr_nxt.addr;
						bitCnt_nxt    = 4'h0;
						bytesDone_nxt = 2'h0;
						state_nxt     = SCP_DATA;
						txByte_nxt    = readByte(instr_nxt.addr,
							cfgRead, rdSel_r);
					end
				end
				SCP_DATA: begin
					shift_nxt  = sh;
					bitCnt_nxt = bitCnt_r + 4'h1;
					if (bitCnt_r == BYTE_LAST) begin
						wrEn          = !instr_r.dir;
						bitCnt_nxt    = 4'h0;
						bytesDone_nxt = bytesDone_r + 2'h1;
						addr_nxt      = stepAddr(addr_r, activeLsb_r);
						txByte_nxt    = readByte(addr_nxt, cfgRead,
							rdSel_r);
						if (instr_r.len != LEN_STREAM
							&& bytesDone_r == instr_r.len)
							state_nxt = SCP_DONE;
					end
				end
				SCP_DONE: begin
					// surplus clocks are ignored until deselect
				end
			endcase
		end else if ((sclkFall || csFall) && state_r == SCP_DATA
			&& instr_r.dir) begin
			// the fall before a read stall may be lost with the
			// deselect, so the resume drives the pending bit
			sdioOe_nxt  = 1'b1;
			sdioOut_nxt = txByte_r[rdBit];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r     <= SCP_INSTR;
			bitCnt_r    <= 4'h0;
			shift_r     <= 16'h0000;
			instr_r     <= '0;
			addr_r      <= 13'h0000;
			bytesDone_r <= 2'h0;
			txByte_r    <= 8'h00;
			sdioOut_r   <= 1'b0;
			sdioOe_r    <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			bitCnt_r    <= bitCnt_nxt;
			shift_r     <= shift_nxt;
			instr_r     <= instr_nxt;
			addr_r      <= addr_nxt;
			bytesDone_r <= bytesDone_nxt;
			txByte_r    <= txByte_nxt;
			sdioOut_r   <= sdioOut_nxt;
			sdioOe_r    <= sdioOe_nxt;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_comb begin
		shadowLsb_nxt  = shadowLsb_r;
		activeLsb_nxt  = activeLsb_r;
		rdSel_nxt      = rdSel_r;
		updStrobe_nxt  = 1'b0;
		srstStrobe_nxt = 1'b0;
		doUpd          = updPinEdge;
		srstHit        = 1'b0;
		// the read-only range and unmapped space fall through
		if (wrEn) begin
			if (wrAddr == CFG_ADDR) begin
				shadowLsb_nxt = wrData[CFG_LSB_BIT];
				srstHit       = wrData[CFG_SRST_BIT];
			end else if (wrAddr == RDSEL_ADDR) begin
				rdSel_nxt = wrData[RDSEL_BIT];
			end else if (wrAddr == UPD_ADDR) begin
				doUpd = doUpd | wrData[UPD_BIT];
			end
		end
		// whole shadow copied in one edge, so no mix is visible
		if (doUpd) begin
			activeLsb_nxt = shadowLsb_nxt;
			updStrobe_nxt = 1'b1;
		end
		// the reset bit is never stored, so it reads back zero
		if (srstHit) begin
			shadowLsb_nxt  = CFG_RST[CFG_LSB_BIT];
			activeLsb_nxt  = CFG_RST[CFG_LSB_BIT];
			rdSel_nxt      = RDSEL_RST[RDSEL_BIT];
			srstStrobe_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			shadowLsb_r  <= CFG_RST[CFG_LSB_BIT];
			activeLsb_r  <= CFG_RST[CFG_LSB_BIT];
			rdSel_r      <= RDSEL_RST[RDSEL_BIT];
			updStrobe_r  <= 1'b0;
			srstStrobe_r <= 1'b0;
		end else begin
			shadowLsb_r  <= shadowLsb_nxt;
			activeLsb_r  <= activeLsb_nxt;
			rdSel_r      <= rdSel_nxt;
			updStrobe_r  <= updStrobe_nxt;
			srstStrobe_r <= srstStrobe_nxt;
		end
	end

	assign sdioOut         = sdioOut_r;
	assign sdioOe          = sdioOe_r;
	assign lsbFirst        = activeLsb_r;
	assign updateStrobe    = updStrobe_r;
	assign softResetStrobe = srstStrobe_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_byteEnd;
		byteEnd;
	endsequence

	sequence s_srstDone;
		!rdSel_r && activeLsb_r == CFG_RST[CFG_LSB_BIT] && srstStrobe_r
		##1 !srstStrobe_r;
	endsequence

	a_oe_release: assert property (!csLow |=> !sdioOe_r)
		else $error("data line driven while deselected");
	a_abort_midbyte: assert property (csRise && !onBoundary
		|=> state_r == SCP_INSTR && bitCnt_r == 4'h0)
		else $error("mid-byte deselect did not reset framing");
	a_stall_keep: assert property (csRise && onBoundary
		&& state_r == SCP_DATA && instr_r.len != LEN_STREAM
		|=> state_r == SCP_DATA && $stable(addr_r))
		else $error("boundary stall lost position");
	a_addr_down: assert property (s_byteEnd ##0 !activeLsb_r
		|=> addr_r == $past(addr_r) - ADDR_STEP)
		else $error("msb-first address did not decrement");
	a_addr_up: assert property (s_byteEnd ##0 activeLsb_r
		|=> addr_r == $past(addr_r) + ADDR_STEP)
		else $error("lsb-first address did not increment");
	a_len_done: assert property (s_byteEnd ##0
		(instr_r.len != LEN_STREAM && bytesDone_r == instr_r.len)
		|=> state_r == SCP_DONE)
		else $error("transfer did not end at its length");
	a_read_drive: assert property (csLow && sclkFall
		&& state_r == SCP_DATA && instr_r.dir
		|=> sdioOe_r ##0 csLow [*1])
		else $error("read data not driven on falling edge");
	a_write_dir: assert property (wrEn |-> !instr_r.dir)
		else $error("write issued during a read cycle");
	a_update_copy: assert property (doUpd && !srstHit
		|=> activeLsb_r == shadowLsb_r && updStrobe_r)
		else $error("update did not copy shadow");
	a_srst_clear: assert property (srstHit |=> s_srstDone)
		else $error("soft reset did not restore defaults");
	a_ro_ignore: assert property (wrEn && wrAddr >= RO_LO_ADDR
		&& wrAddr <= RO_HI_ADDR && !updPinEdge
		|=> $stable(shadowLsb_r) && $stable(rdSel_r))
		else $error("read-only write changed state");
	a_cfg_mirror: assert property (cfgRead[3:0] == {cfgRead[4],
		cfgRead[5], cfgRead[6], cfgRead[7]} && cfgRead[4])
		else $error("config nibble mirror broken");

endmodule

// ==== scp_pkg.sv ====
// constants, types and field layout of the serial control port slave
package scp_pkg;

	// ------------------------------------------------------------
	// address map and fields
	// ------------------------------------------------------------
	localparam int          ADDR_W       = 13;
	localparam logic [12:0] CFG_ADDR     = 13'h0000;
	localparam logic [12:0] RO_LO_ADDR   = 13'h0001;
	localparam logic [12:0] RO_HI_ADDR   = 13'h0003;
	localparam logic [12:0] RDSEL_ADDR   = 13'h0004;
	localparam logic [12:0] UPD_ADDR     = 13'h0005;
	localparam logic [12:0] ADDR_STEP    = 13'h0001;
	localparam logic [7:0]  CFG_RST      = 8'h18;
	localparam logic [7:0]  RDSEL_RST    = 8'h00;
	localparam int          CFG_LSB_BIT  = 6;
	localparam int          CFG_SRST_BIT = 5;
	localparam int          RDSEL_BIT    = 0;
	localparam int          UPD_BIT      = 0;

	// ------------------------------------------------------------
	// framing counts
	// ------------------------------------------------------------
	localparam logic [3:0]  INSTR_LAST   = 4'hf;
	localparam logic [3:0]  BYTE_LAST    = 4'h7;
	localparam logic [1:0]  LEN_STREAM   = 2'h3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SCP_INSTR = 2'h0,
		SCP_DATA  = 2'h1,
		SCP_DONE  = 2'h3
	} scp_state_e;

	typedef struct packed {
		logic        dir;
		logic [1:0]  len;
		logic [12:0] addr;
	} scp_instr_s;

	typedef struct packed {
		logic sclk;
		logic csN;
		logic sdio;
		logic ioUpd;
	} scp_pins_s;

	localparam scp_pins_s PINS_RST = '{sclk: 1'b0, csN: 1'b1,
		sdio: 1'b0, ioUpd: 1'b0};

endpackage

// ==== scp_host_model.sv ====
// host-side model of the three-wire serial master used by the bench
`timescale 1ns/1ps
module scp_host_model (
	input  wire logic ref_clk, // bench clock, pins move on its fall
	input  wire logic sdioW,   // resolved data line
	output logic      sclk,    // shift clock, idles low
	output logic      csN,     // chip select, active low
	output logic      hostDrv  // host data, junk while released
);
	logic hostOe;
	logic hostD;
	logic flt;
	logic lsbMode;
	// a released line flips on every shift so it never holds a level
	assign hostDrv = hostOe ? hostD : flt;
	always @(posedge sclk) flt <= ~flt;
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		hostOe = 1'b0;
		hostD = 1'b0;
		lsbMode = 1'b0;
		flt = 1'b0;
	end
	// brk: bit count where chip select rises; on a byte edge it resumes
	task automatic frame(logic [15:0] ins, int nb, logic [31:0] wd,
		int brk, output logic [31:0] rd);
		int n;
		int k;
		n = 16 + 8 * nb;
		rd = '0;
		csN = 1'b0;
		repeat (4) @(negedge ref_clk);
		for (int i = 0; i < n; i++) begin
			if (i == brk) begin
				csN = 1'b1;
				hostOe = 1'b0;
				repeat (8) @(negedge ref_clk);
				if (i % 8 != 0)
					break;
				csN = 1'b0;
				repeat (4) @(negedge ref_clk);
			end
			k = lsbMode ? i % 8 : 7 - i % 8;
			hostOe = (i < 16) || !ins[15];
			hostD = (i < 16) ? ins[lsbMode ? i : 15 - i]
				: wd[8 * (i / 8 - 2) + k];
			repeat (4) @(negedge ref_clk);
			sclk = 1'b1;
			repeat (4) @(negedge ref_clk);
			if (i >= 16)
				rd[8 * (i / 8 - 2) + k] = sdioW;
			sclk = 1'b0;
		end
		csN = 1'b1;
		hostOe = 1'b0;
		repeat (12) @(negedge ref_clk);
	endtask
	task automatic idle();
		for (int i = 0; i < 16; i++) begin
			repeat (4) @(negedge ref_clk);
			sclk = ~sclk;
		end
	endtask
endmodule

// ==== serial_control_port_slave_tb.sv ====
// self-checking bench for the serial control port slave
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checksDone++; if ((gt) !== (ex)) begin \
	numErrors++; $display("ERROR %s exp %h got %h", nm, ex, gt); end end
module serial_control_port_slave_tb;
	import scp_pkg::*;
	localparam int NB = 999;
	logic ref_clk;
	logic rst;
	logic ioUpdate;
	wire  sclk;
	wire  csN;
	wire  hostDrv;
	wire  sdioW;
	logic sdioOut;
	logic sdioOe;
	logic lsbFirst;
	logic updateStrobe;
	logic softResetStrobe;
	int   numErrors = 0;
	int   checksDone = 0;
	int   updSeen = 0;
	int   rstSeen = 0;
	int   updExp = 0;
	int   rstExp = 0;
	logic shL;
	logic acL;
	logic rsel;
	logic [7:0] r;
	assign sdioW = sdioOe ? sdioOut : hostDrv;
	scp_serial_port DUT (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
		.csN(csN), .sdioIn(sdioW), .sdioOut(sdioOut), .sdioOe(sdioOe),
		.ioUpdate(ioUpdate), .lsbFirst(lsbFirst),
		.updateStrobe(updateStrobe), .softResetStrobe(softResetStrobe));
	scp_host_model host (.ref_clk(ref_clk), .sdioW(sdioW), .sclk(sclk),
		.csN(csN), .hostDrv(hostDrv));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) begin
		if (updateStrobe === 1'b1)
			updSeen++;
		if (softResetStrobe === 1'b1)
			rstSeen++;
	end
	// ------------------------------------------------------------
	// reference model
	// ------------------------------------------------------------
	function automatic logic [7:0] expRd(logic [12:0] a);
		logic l;
		l = rsel ? shL : acL;
		if (a == CFG_ADDR)
			return 8'h18 | {1'b0, l, 4'h0, l, 1'b0};
		if (a == RDSEL_ADDR)
			return {7'h0, rsel};
		return 8'h00;
	endfunction
	task automatic modelWr(logic [12:0] a, logic [7:0] d);
		if (a == CFG_ADDR && d[5]) begin
			shL = 1'b0;
			acL = 1'b0;
			rsel = 1'b0;
			rstExp++;
		end else if (a == CFG_ADDR)
			shL = d[6];
		else if (a == RDSEL_ADDR)
			rsel = d[0];
		else if (a == UPD_ADDR && d[0]) begin
			acL = shL;
			updExp++;
		end
	endtask
	task automatic op(string nm, logic [15:0] ins, logic [31:0] wd, int brk);
		int nb;
		logic [12:0] ad;
		logic [31:0] rd;
		nb = (ins[14:13] == LEN_STREAM) ? 4 : ins[14:13] + 1;
		ad = ins[12:0];
		host.lsbMode = acL;
		host.frame(ins, nb, wd, brk, rd);
		for (int k = 0; k < nb; k++) begin
			// only whole bytes before a mid-byte deselect count
			if (brk % 8 == 0 || brk >= 24 + 8 * k) begin
				if (ins[15]) `CHK(nm, expRd(ad), rd[8*k +: 8])
				else modelWr(ad, wd[8*k +: 8]);
			end
			ad = acL ? ad + 13'h1 : ad - 13'h1;
		end
		`CHK("order", acL, lsbFirst)
		`CHK("updates", updExp, updSeen)
		`CHK("resets", rstExp, rstSeen)
		`CHK("release", 1'b0, sdioOe)
	endtask
	task automatic pinUpd();
		ioUpdate = 1'b1;
		repeat (8) @(negedge ref_clk);
		ioUpdate = 1'b0;
		repeat (8) @(negedge ref_clk);
		acL = shL;
		updExp++;
		`CHK("pin order", acL, lsbFirst)
		`CHK("pin updates", updExp, updSeen)
	endtask
	task automatic completeRun();
		$display("checks %0d errors %0d", checksDone, numErrors);
		if (numErrors == 0 && checksDone > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge ref_clk);
		numErrors++;
		completeRun();
	end
	initial begin
		rst = 1'b1;
		ioUpdate = 1'b0;
		shL = 1'b0;
		acL = 1'b0;
		rsel = 1'b0;
		r = 8'($urandom(32'h01f0ba0f));
		repeat (20) @(posedge ref_clk);
		@(negedge ref_clk) rst = 1'b0;
		`CHK("rst order", 1'b0, lsbFirst)
		repeat (4) @(negedge ref_clk);
		op("cfg", 16'h8000, 0, NB);
		op("rdsel", 16'h8004, 0, NB);
		op("upd rd", 16'h8005, 0, NB);
		$display("test defaults done");
		op("cfg wr", 16'h0000, 32'h40, NB);
		op("cfg", 16'h8000, 0, NB);
		op("rdsel stall", 16'h2004, 32'hff01, 24);
		op("cfg stall", 16'h8000, 0, 8);
		$display("test shadow done");
		op("upd", 16'h0005, 1, NB);
		op("stream", 16'he003, 0, NB);
		op("stream wr", 16'h6002, 32'h0000ffff, NB);
		op("ro", 16'ha001, 0, NB);
		$display("test lsb done");
		op("cfg wr", 16'h0000, 0, NB);
		pinUpd();
		op("msb", 16'hc002, 0, NB);
		op("rd stall", 16'h8000, 0, 16);
		$display("test pin done");
		op("abort", 16'h0004, 1, 20);
		op("abort", 16'h0004, 1, 12);
		op("rdsel", 16'h8004, 0, NB);
		host.idle();
		`CHK("idle oe", 1'b0, sdioOe)
		op("cfg", 16'h8000, 0, NB);
		$display("test abort done");
		op("rdsel wr", 16'h0004, 1, NB);
		op("cfg wr", 16'h0000, 32'h40, NB);
		op("srst", 16'h0000, 32'h20, NB);
		op("cfg", 16'h8000, 0, NB);
		op("rdsel", 16'h8004, 0, NB);
		$display("test soft reset done");
		repeat (6) begin
			r = 8'($urandom);
			op("rnd", 16'h0004, {24'h0, r}, NB);
			op("rnd", 16'h8004, 0, NB);
			op("rnd cfg", 16'h0000, {24'h0, r & 8'hdf}, NB);
			pinUpd();
			op("rnd", 16'h8000, 0, NB);
		end
		$display("test random done");
		completeRun();
	end
endmodule
